//--- logic/stc_cal_regs.svh
// Register indices, field positions, reset values and limits of the timing calibration block
`ifndef STC_CAL_REGS_SVH
`define STC_CAL_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define STC_IDX_ENABLE      10'h2b0
`define STC_IDX_CONFIG      10'h2b1
`define STC_IDX_RESULT      10'h2b2
`define STC_IDX_MANUAL      10'h2b5
`define STC_IDX_RAMP        10'h2b8
`define STC_IDX_RSV_LO      10'h2b9
`define STC_IDX_RSV_HI      10'h2bf
`define STC_IDX_IRQ_STATUS  10'h2c0
`define STC_IDX_IRQ_CLEAR   10'h2c1
`define STC_IDX_IRQ_ENABLE  10'h2c2

// Reset values
`define STC_ENABLE_RST      8'h00
`define STC_CONFIG_RST      8'h05
`define STC_MANUAL_RST      24'h000000
`define STC_RAMP_RST        8'h00
`define STC_RESULT_RST      17'h00000
`define STC_DELAY_RST       17'h00000

// Field positions
`define STC_ENABLE_BIT      0
`define STC_DONE_BIT        17
`define STC_DELAY_W         17
`define STC_IRQ_DONE_BIT    0
`define STC_IRQ_FAIL_BIT    1
`define STC_IRQ_W           2

// Longest timing reference period per duration code, in clock cycles
`define STC_PERIOD_MAX_0    16'd85
`define STC_PERIOD_MAX_1    16'd1100
`define STC_PERIOD_MAX_2    16'd5200
`define STC_PERIOD_MAX_3    16'd21580

// Number of averaged samples per averaging code
`define STC_AVG_CNT_0       9'd4
`define STC_AVG_CNT_1       9'd16
`define STC_AVG_CNT_2       9'd64
`define STC_AVG_CNT_3       9'd256

`endif

//--- logic/stc_pkg.sv
// Types shared by the timing calibration register block
package stc_pkg;

    typedef enum logic [2:0] {
        STC_IDLE  = 3'b000,
        STC_WAIT  = 3'b001,
        STC_ACCUM = 3'b010,
        STC_DONE  = 3'b011,
        STC_FAIL  = 3'b100
    } stc_state_e;

    typedef struct packed {
        logic [3:0] reserved;
        logic [1:0] avg_sel;
        logic [1:0] accum_dur;
    } stc_config_s;

    typedef struct packed {
        logic                 done;
        logic [16:0]          delay;
    } stc_result_s;

endpackage : stc_pkg

//--- logic/stc_cal_top.sv
// Timing reference calibration control and status registers with APB slave and calibration engine
//
// Functional notes
// - Enable clear: no calibration, delay output follows the manual delay register.
// - Enable set: delay comes from a finished calibration and holds its last value until then; manual register is ignored.
// - Calibration starts only on a zero-to-one change of the enable bit.
// - Enable register at 0x2B0, reset 0x00, bit 0 enable, bits 7..1 read/write.
// - Configuration at 0x2B1, reset 0x05, averaging bits 3..2, duration bits 1..0.
// - Group spans 0x2B0..0x2BF; status three bytes at 0x2B2; 0x2B9..0x2BF reserved.
// - Manual delay at 0x2B5..0x2B7 resets to zero; ramp control 0x2B8 resets zero.
// - Averaging codes 0..3 select 4, 16, 64 or 256 averages.
// - Duration codes allow reference periods up to 85, 1100, 5200, 21580 cycles.
// - Completion bit 17 is one only while enabled and finished; delay valid then.
//
// Implementation choice: the APB register port.

`include "stc_cal_regs.svh"

module stc_cal_top
    import stc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_SYS_RST,
    input  wire logic              I_CLK_EN,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [31:0]       I_PWDATA,
    output logic [31:0]            O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    input  wire logic              I_SYSREF,
    input  wire logic [16:0]       I_CAL_PHASE,
    output logic [16:0]            O_CLOCK_DELAY,
    output logic [7:0]             O_DELAY_RAMP_CTRL,
    output logic                   O_CAL_BUSY,
    output logic                   O_IRQ
);

    // Bus decode
    logic [9:0]  reg_idx;
    logic        access;
    logic        wr_en;
    logic        hit_enable;
    logic        hit_config;
    logic        hit_result;
    logic        hit_manual;
    logic        hit_ramp;
    logic        hit_rsv;
    logic        hit_irq_stat;
    logic        hit_irq_clr;
    logic        hit_irq_en;
    logic        mapped;
    logic        ro_target;

    assign reg_idx      = I_PADDR[ADDR_W-1:2];
    assign access       = I_PSEL && I_PENABLE && I_CLK_EN;
    assign wr_en        = access && I_PWRITE;
    assign hit_enable   = (reg_idx == `STC_IDX_ENABLE);
    assign hit_config   = (reg_idx == `STC_IDX_CONFIG);
    assign hit_result   = (reg_idx == `STC_IDX_RESULT);
    assign hit_manual   = (reg_idx == `STC_IDX_MANUAL);
    assign hit_ramp     = (reg_idx == `STC_IDX_RAMP);
    assign hit_rsv      = (reg_idx >= `STC_IDX_RSV_LO) && (reg_idx <= `STC_IDX_RSV_HI);
    assign hit_irq_stat = (reg_idx == `STC_IDX_IRQ_STATUS);
    assign hit_irq_clr  = (reg_idx == `STC_IDX_IRQ_CLEAR);
    assign hit_irq_en   = (reg_idx == `STC_IDX_IRQ_ENABLE);
    assign mapped       = hit_enable | hit_config | hit_result | hit_manual | hit_ramp
                        | hit_rsv | hit_irq_stat | hit_irq_clr | hit_irq_en;
    // Read-only words: the result and the interrupt status registers
    assign ro_target    = hit_result | hit_irq_stat;

    // Zero-wait slave; a frozen clock enable stretches the access phase
    assign O_PREADY  = I_CLK_EN;
    assign O_PSLVERR = access && (!mapped || (I_PWRITE && ro_target));

    // Software registers
    logic [7:0]                enable_q;
    logic [7:0]                enable_d;
    stc_config_s               config_q;
    stc_config_s               config_d;
    logic [23:0]               manual_q;
    logic [23:0]               manual_d;
    logic [7:0]                ramp_q;
    logic [7:0]                ramp_d;
    logic [`STC_IRQ_W-1:0]     irq_en_q;
    logic [`STC_IRQ_W-1:0]     irq_en_d;

    always_comb begin
        enable_d = enable_q;
        config_d = config_q;
        manual_d = manual_q;
        ramp_d   = ramp_q;
        irq_en_d = irq_en_q;
        if (wr_en) begin
            if (hit_enable) begin
                enable_d = I_PWDATA[7:0];
            end
            if (hit_config) begin
                config_d = stc_config_s'(I_PWDATA[7:0]);
            end
            if (hit_manual) begin
                manual_d = I_PWDATA[23:0];
            end
            if (hit_ramp) begin
                ramp_d = I_PWDATA[7:0];
            end
            if (hit_irq_en) begin
                irq_en_d = I_PWDATA[`STC_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            enable_q <= `STC_ENABLE_RST;
            config_q <= stc_config_s'(`STC_CONFIG_RST);
            manual_q <= `STC_MANUAL_RST;
            ramp_q   <= `STC_RAMP_RST;
            irq_en_q <= '0;
        end else if (I_CLK_EN) begin
            enable_q <= enable_d;
            config_q <= config_d;
            manual_q <= manual_d;
            ramp_q   <= ramp_d;
            irq_en_q <= irq_en_d;
        end
    end

    // Timing reference pin synchroniser; first stage feeds only the second
    logic sysref_meta_q;
    logic sysref_sync_q;
    logic sysref_prev_q;
    logic sysref_rise;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            sysref_meta_q <= 1'b0;
            sysref_sync_q <= 1'b0;
            sysref_prev_q <= 1'b0;
        end else if (I_CLK_EN) begin
            sysref_meta_q <= I_SYSREF;
            sysref_sync_q <= sysref_meta_q;
            sysref_prev_q <= sysref_sync_q;
        end
    end

    assign sysref_rise = sysref_sync_q && !sysref_prev_q;

    // Calibration engine
    logic        cal_on;
    logic        cal_on_prev_q;
    logic        cal_start;
    logic [15:0] period_max;
    logic [8:0]  avg_target;
    logic [3:0]  avg_shift;

    assign cal_on    = enable_q[`STC_ENABLE_BIT];
    assign cal_start = cal_on && !cal_on_prev_q;

    always_comb begin
        unique case (config_q.accum_dur)
            2'b00: period_max = `STC_PERIOD_MAX_0;
            2'b01: period_max = `STC_PERIOD_MAX_1;
            2'b10: period_max = `STC_PERIOD_MAX_2;
            2'b11: period_max = `STC_PERIOD_MAX_3;
        endcase
        unique case (config_q.avg_sel)
            2'b00: begin
                avg_target = `STC_AVG_CNT_0;
                avg_shift  = 4'd2;
            end
            2'b01: begin
                avg_target = `STC_AVG_CNT_1;
                avg_shift  = 4'd4;
            end
            2'b10: begin
                avg_target = `STC_AVG_CNT_2;
                avg_shift  = 4'd6;
            end
            2'b11: begin
                avg_target = `STC_AVG_CNT_3;
                avg_shift  = 4'd8;
            end
        endcase
    end

    stc_state_e  state_q;
    stc_state_e  state_d;
    logic [15:0] period_q;
    logic [15:0] period_d;
    logic [8:0]  samples_q;
    logic [8:0]  samples_d;
    logic [24:0] sum_q;
    logic [24:0] sum_d;
    stc_result_s result_q;
    stc_result_s result_d;
    logic        ev_done;
    logic        ev_fail;
    logic [24:0] sum_next;
    logic [24:0] avg_value;

    assign sum_next  = sum_q + {8'h00, I_CAL_PHASE};
    assign avg_value = sum_next >> avg_shift;

    always_comb begin
        state_d   = state_q;
        period_d  = period_q;
        samples_d = samples_q;
        sum_d     = sum_q;
        result_d  = result_q;
        ev_done   = 1'b0;
        ev_fail   = 1'b0;
        if (!cal_on) begin
            // Dropping enable abandons any run and clears completion
            state_d       = STC_IDLE;
            result_d.done = 1'b0;
        end else if (cal_start) begin
            state_d       = STC_WAIT;
            samples_d     = '0;
            sum_d         = '0;
            result_d.done = 1'b0;
        end else begin
            unique case (state_q)
                STC_IDLE, STC_DONE, STC_FAIL: begin
                    state_d = state_q;
                end
                STC_WAIT: begin
                    // Waits for a first reference edge indefinitely; the old delay stays, completion is already cleared
                    if (sysref_rise) begin
                        state_d  = STC_ACCUM;
                        period_d = '0;
                    end
                end
                STC_ACCUM: begin
                    if (sysref_rise) begin
                        period_d = '0;
                        sum_d    = sum_next;
                        samples_d = samples_q + 9'd1;
                        if (samples_q + 9'd1 == avg_target) begin
                            state_d        = STC_DONE;
                            result_d.delay = avg_value[16:0];
                            result_d.done  = 1'b1;
                            ev_done        = 1'b1;
                        end
                    // Fail as soon as the gap exceeds the limit, so a longer period never passes
                    end else if (period_q + 16'd1 >= period_max) begin
                        state_d = STC_FAIL;
                        ev_fail = 1'b1;
                    end else begin
                        period_d = period_q + 16'd1;
                    end
                end
                default: begin
                    state_d = STC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            state_q       <= STC_IDLE;
            cal_on_prev_q <= 1'b0;
            period_q      <= '0;
            samples_q     <= '0;
            sum_q         <= '0;
            result_q      <= {1'b0, `STC_RESULT_RST};
        end else if (I_CLK_EN) begin
            state_q       <= state_d;
            cal_on_prev_q <= cal_on;
            period_q      <= period_d;
            samples_q     <= samples_d;
            sum_q         <= sum_d;
            result_q      <= result_d;
        end
    end

    // Interrupt status: a new event wins over a simultaneous clear
    logic [`STC_IRQ_W-1:0] irq_stat_q;
    logic [`STC_IRQ_W-1:0] irq_stat_d;
    logic [`STC_IRQ_W-1:0] irq_events;
    logic [`STC_IRQ_W-1:0] irq_clear;

    always_comb begin
        irq_events                    = '0;
        irq_events[`STC_IRQ_DONE_BIT] = ev_done;
        irq_events[`STC_IRQ_FAIL_BIT] = ev_fail;
        irq_clear  = (wr_en && hit_irq_clr) ? I_PWDATA[`STC_IRQ_W-1:0] : '0;
        irq_stat_d = (irq_stat_q & ~irq_clear) | irq_events;
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            irq_stat_q <= '0;
        end else if (I_CLK_EN) begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // Outputs registered from state
    logic [16:0] delay_out_q;
    logic [16:0] delay_out_d;
    logic        irq_q;
    logic        irq_d;
    logic        busy_q;
    logic        busy_d;

    always_comb begin
        // Manual value steers the clock only while calibration is off
        if (!enable_d[`STC_ENABLE_BIT]) begin
            delay_out_d = manual_d[16:0];
        end else if (result_d.done) begin
            delay_out_d = result_d.delay;
        end else begin
            delay_out_d = delay_out_q;
        end
        irq_d  = |(irq_stat_d & irq_en_d);
        busy_d = (state_d == STC_WAIT) || (state_d == STC_ACCUM);
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            delay_out_q <= `STC_DELAY_RST;
            irq_q       <= 1'b0;
            busy_q      <= 1'b0;
        end else if (I_CLK_EN) begin
            delay_out_q <= delay_out_d;
            irq_q       <= irq_d;
            busy_q      <= busy_d;
        end
    end

    assign O_CLOCK_DELAY     = delay_out_q;
    assign O_DELAY_RAMP_CTRL = ramp_q;
    assign O_CAL_BUSY        = busy_q;
    assign O_IRQ             = irq_q;

    // Read data is registered so it stands stable after the access edge
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            rdata_d = '0;
            if (hit_enable) begin
                rdata_d[7:0] = enable_q;
            end
            if (hit_config) begin
                rdata_d[7:0] = config_q;
            end
            if (hit_result) begin
                // Completion is qualified by the live enable bit
                rdata_d[`STC_DONE_BIT]  = result_q.done && cal_on;
                rdata_d[16:0]           = result_q.delay;
            end
            if (hit_manual) begin
                rdata_d[23:0] = manual_q;
            end
            if (hit_ramp) begin
                rdata_d[7:0] = ramp_q;
            end
            if (hit_irq_stat) begin
                rdata_d[`STC_IRQ_W-1:0] = irq_stat_q;
            end
            if (hit_irq_en) begin
                rdata_d[`STC_IRQ_W-1:0] = irq_en_q;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            rdata_q <= '0;
        end else if (I_CLK_EN) begin
            rdata_q <= rdata_d;
        end
    end

    assign O_PRDATA = rdata_q;

endmodule : stc_cal_top

//--- verification/stc_cal_props.sv
// Port-level assertions for the timing calibration register block
`include "stc_cal_regs.svh"

module stc_cal_props
    import stc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              I_SYS_CLK,
    input wire logic              I_SYS_RST,
    input wire logic              I_CLK_EN,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic              I_PSEL,
    input wire logic              I_PENABLE,
    input wire logic              I_PWRITE,
    input wire logic [31:0]       I_PWDATA,
    input wire logic [31:0]       O_PRDATA,
    input wire logic              O_PREADY,
    input wire logic              O_PSLVERR,
    input wire logic              I_SYSREF,
    input wire logic [16:0]       I_CAL_PHASE,
    input wire logic [16:0]       O_CLOCK_DELAY,
    input wire logic [7:0]        O_DELAY_RAMP_CTRL,
    input wire logic              O_CAL_BUSY,
    input wire logic              O_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] idx;
    logic       acc;
    logic       wr;
    logic       rsv;
    logic       en_q;
    logic [1:0] ien_q;
    assign idx = I_PADDR[ADDR_W-1:2];
    assign acc = I_PSEL && I_PENABLE && I_CLK_EN;
    assign wr  = acc && I_PWRITE;
    assign rsv = idx >= `STC_IDX_RSV_LO && idx <= `STC_IDX_RSV_HI;
    // Shadow copies of the enables, so the checker need not peek inside
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            en_q  <= 1'b0;
            ien_q <= 2'b00;
        end else begin
            if (wr && idx == `STC_IDX_ENABLE) en_q <= I_PWDATA[0];
            if (wr && idx == `STC_IDX_IRQ_ENABLE) ien_q <= I_PWDATA[1:0];
        end
    end
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    AST_RST_OUT: assert property ($fell(I_SYS_RST) |-> O_CLOCK_DELAY == 17'h00000 && !O_CAL_BUSY
        && !O_IRQ && O_DELAY_RAMP_CTRL == 8'h00) else $error("outputs not cleared by reset");
    AST_MANUAL_DRIVE: assert property (wr && idx == `STC_IDX_MANUAL && !en_q |=>
        O_CLOCK_DELAY == $past(I_PWDATA[16:0])) else $error("delay does not follow manual value");
    AST_MANUAL_IGNORED: assert property (wr && idx == `STC_IDX_MANUAL && en_q && !O_CAL_BUSY |=>
        $stable(O_CLOCK_DELAY)) else $error("manual value leaked while enabled");
    AST_START_BUSY: assert property (wr && idx == `STC_IDX_ENABLE && I_PWDATA[0] && !en_q |->
        ##[1:2] O_CAL_BUSY) else $error("calibration did not start");
    AST_NO_RESTART: assert property (wr && idx == `STC_IDX_ENABLE && I_PWDATA[0] && en_q && !O_CAL_BUSY
        |=> !O_CAL_BUSY [*3]) else $error("calibration restarted without rising enable");
    AST_RESULT_RO: assert property (wr && idx == `STC_IDX_RESULT |-> O_PSLVERR)
        else $error("write to result accepted");
    AST_RSV_NO_ERR: assert property (acc && rsv |-> !O_PSLVERR)
        else $error("reserved access flagged");
    AST_RSV_READ0: assert property (acc && !I_PWRITE && rsv |-> O_PRDATA == 32'h00000000)
        else $error("reserved read not zero");
    AST_IRQ_MASKED: assert property (ien_q == 2'b00 && $past(ien_q) == 2'b00 |-> !O_IRQ)
        else $error("interrupt while masked");
endmodule : stc_cal_props

bind stc_cal_top stc_cal_props #(.ADDR_W(ADDR_W)) u_props (
    .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_CLK_EN(I_CLK_EN), .I_PADDR(I_PADDR),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_SYSREF(I_SYSREF),
    .I_CAL_PHASE(I_CAL_PHASE), .O_CLOCK_DELAY(O_CLOCK_DELAY), .O_DELAY_RAMP_CTRL(O_DELAY_RAMP_CTRL),
    .O_CAL_BUSY(O_CAL_BUSY), .O_IRQ(O_IRQ));

//--- verification/stc_sysref_src.sv
// Timing reference pulse source and phase detector model for the block's far side
module stc_sysref_src (
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic [15:0] i_period,
    input  wire logic [16:0] i_phase,
    output logic             o_sysref,
    output logic [16:0]      o_phase
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_q;
    always @(posedge i_clk) begin
        if (!i_run) begin
            cnt_q    <= 16'h0000;
            o_sysref <= 1'b0;
        end else begin
            cnt_q    <= (cnt_q == i_period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
            o_sysref <= cnt_q < 16'h0008;
        end
    end
    // Phase is only meaningful near a pulse; scrambled elsewhere so a late sample shows up
    assign o_phase = o_sysref ? i_phase : ~i_phase;
endmodule : stc_sysref_src

//--- verification/tb_sysref_timing_calibration_regs.sv
// Self-checking bench for the timing calibration register block
`include "stc_cal_regs.svh"

module tb_sysref_timing_calibration_regs;
    import stc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, clk_en = 1, psel = 0, pen = 0, pwr = 0, run = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, err, irq, busy, sref;
    logic [16:0] delay, ph_pin, phase = '0;
    logic [15:0] per = 16'd40;
    logic [7:0]  ramp;
    int          fails = 0, checks_done = 0, n;
    always #5 clk = ~clk;
    stc_cal_top u_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(clk_en), .I_PADDR(paddr), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_SYSREF(sref), .I_CAL_PHASE(ph_pin), .O_CLOCK_DELAY(delay),
        .O_DELAY_RAMP_CTRL(ramp), .O_CAL_BUSY(busy), .O_IRQ(irq));
    stc_sysref_src u_src (.i_clk(clk), .i_run(run), .i_period(per), .i_phase(phase), .o_sysref(sref),
        .o_phase(ph_pin));
    task end_sim;
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= {idx, 2'b00}; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(0, 1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task wr(input logic [9:0] idx, input logic [31:0] d); apb(1, idx, d); endtask : wr
    task rd(input logic [9:0] idx, input logic [31:0] e); apb(0, idx, 0); chk(q, e); endtask : rd
    task cyc(input int k); repeat (k) @(posedge clk); #1; endtask : cyc
    task wait_idle(input int lim);
        n = 0;
        while (busy === 1'b1 && n < lim) begin cyc(1); n++; end
    endtask : wait_idle
    task t_reset;
        rd(`STC_IDX_ENABLE, 32'h0);
        rd(`STC_IDX_CONFIG, 32'h5);
        rd(`STC_IDX_RESULT, 32'h0);
        rd(`STC_IDX_MANUAL, 32'h0);
        rd(`STC_IDX_RAMP, 32'h0);
        rd(`STC_IDX_RSV_HI, 32'h0);
        chk(delay, 0);
    endtask : t_reset
    task t_regs;
        wr(`STC_IDX_ENABLE, 32'hfe); rd(`STC_IDX_ENABLE, 32'hfe);
        wr(`STC_IDX_CONFIG, 32'hff); rd(`STC_IDX_CONFIG, 32'hff);
        wr(`STC_IDX_MANUAL, 32'habcdef); cyc(1); chk(delay, 17'h1cdef);
        rd(`STC_IDX_MANUAL, 32'habcdef);
        wr(`STC_IDX_RAMP, 32'h5a); cyc(1); chk(ramp, 8'h5a);
        wr(`STC_IDX_RESULT, 32'h1); chk(err, 1);
        wr(10'h2b3, 32'h1); chk(err, 1);
        wr(`STC_IDX_RSV_LO, 32'hffffffff); chk(err, 0); rd(`STC_IDX_RSV_LO, 32'h0);
    endtask : t_regs
    task t_cal(input int code);
        int nn;
        nn = 4 << (2 * code);
        phase <= 17'h1a5a0 + code[16:0];
        per <= 16'd40;
        wr(`STC_IDX_CONFIG, code * 4 + 1); // Settings go in before enable
        wr(`STC_IDX_ENABLE, 32'h1); // Converter calibration is never running here
        run <= 1;
        cyc(3);
        wait_idle(20000);
        chk(n + 3 >= nn * 40 && n + 3 <= nn * 40 + 40, 1);
        chk(delay, 17'h1a5a0 + code);
        rd(`STC_IDX_RESULT, 32'h20000 | (32'h1a5a0 + code));
        wr(`STC_IDX_MANUAL, 32'h0); cyc(1); chk(delay, 17'h1a5a0 + code);
        wr(`STC_IDX_ENABLE, 32'h1); cyc(2); chk(busy, 0);
        run <= 0;
        if (code == 3) begin
            chk(irq, 0);
            wr(`STC_IDX_IRQ_ENABLE, 32'h1); cyc(2); chk(irq, 1);
            rd(`STC_IDX_IRQ_STATUS, 32'h1);
            wr(`STC_IDX_IRQ_CLEAR, 32'h3); cyc(2); chk(irq, 0);
            wr(`STC_IDX_IRQ_ENABLE, 32'h0);
        end
        wr(`STC_IDX_ENABLE, 32'h0);
        // Completion drops with enable; the last computed delay stays readable
        rd(`STC_IDX_RESULT, 32'h1a5a0 + code);
        chk(delay, 0);
    endtask : t_cal
    task t_nopulse;
        wr(`STC_IDX_MANUAL, 32'h12345);
        wr(`STC_IDX_CONFIG, 32'h5);
        wr(`STC_IDX_ENABLE, 32'h1);
        cyc(300);
        chk(busy, 1); chk(delay, 17'h12345);
        apb(0, `STC_IDX_RESULT, 0); chk(q[17], 0);
        wr(`STC_IDX_ENABLE, 32'h0);
    endtask : t_nopulse
    task t_fail;
        per <= 16'd200;
        wr(`STC_IDX_CONFIG, 32'h0);
        wr(`STC_IDX_ENABLE, 32'h1);
        run <= 1;
        cyc(3);
        wait_idle(1000);
        chk(n >= 70 && n <= 130, 1);
        apb(0, `STC_IDX_RESULT, 0); chk(q[17], 0);
        chk(delay, 17'h12345);
        apb(0, `STC_IDX_IRQ_STATUS, 0); chk(q[1], 1);
        run <= 0;
        wr(`STC_IDX_ENABLE, 32'h0);
        wr(`STC_IDX_IRQ_CLEAR, 32'h3);
    endtask : t_fail
    // Clock enable low stretches a write and freezes the delay; then a mid-run reset
    task t_freeze;
        clk_en <= 1'b0;
        fork
            wr(`STC_IDX_MANUAL, 32'h00777);
            begin
                cyc(4);
                chk(pready, 0);
                chk(delay, 17'h12345);
                @(posedge clk);
                clk_en <= 1'b1;
            end
        join
        cyc(1);
        chk(delay, 17'h00777);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`STC_IDX_MANUAL, 32'h0);
        chk(delay, 0);
    endtask : t_freeze
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        for (int c = 0; c < 4; c++) t_cal(c);
        t_nopulse;
        t_fail;
        t_freeze;
        end_sim;
    end
    // Whole run needs about 15k cycles; a hang is cut off well beyond that
    initial begin
        #300000;
        fails++;
        end_sim;
    end
endmodule : tb_sysref_timing_calibration_regs
